// [inc/ccpm_pkg.sv]
// Purpose: shared constants and carriers for the capture/compare pin mux
// Assumes: 100 MHz system clock, synchronous active-high reset
// Notes:   times are in picoseconds so both tick rates are whole numbers
`default_nettype none
package ccpm_pkg;
   localparam int unsigned CLK_PERIOD_PS  = 10000;               // 10 ns clock
   localparam int unsigned TICK_SLOW_PS   = 1000000;             // 1 us per count
   localparam int unsigned TICK_FAST_PS   = 500000;              // 0.5 us per count
   localparam int unsigned TICK_SLOW_CYC  = (TICK_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TICK_FAST_CYC  = (TICK_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TIMER_W        = 16;
   localparam int unsigned PIN_COUNT      = 5;
   localparam logic [1:0]  DI_SEL_SERIAL2 = 2'h1;                // two-wire serial select code
   localparam logic [15:0] TIMER_RESET    = 16'h0000;
   localparam logic [4:0]  PIN_OE_RESET   = 5'h00;               // all pins input after reset
   localparam int unsigned PIN_ONE        = 0;                   // port 2.0, capture 1, serial data
   localparam int unsigned PIN_TWO        = 1;                   // port 2.1, capture 2
   localparam int unsigned PIN_THREE      = 2;                   // port 2.2, compare 1, serial clock
   localparam int unsigned PIN_FOUR       = 3;                   // port 2.3, compare 2
   localparam int unsigned PIN_FIVE       = 4;                   // port 3.2 only

   typedef struct packed {
      logic       capture_one_enable;
      logic       capture_two_enable;
      logic       compare_one_enable;
      logic       compare_two_enable;
   } ccpm_pin_select_t;

   typedef struct packed {
      logic       tick_rate_select;        // 1: 0.5 us per count
      logic [1:0] capture_edge_select;     // per channel, 1: rising edge
      logic       compare_one_match_level;
      logic       compare_two_match_level;
   } ccpm_control_t;

   typedef struct packed {
      logic       out;
      logic       oe;
   } ccpm_drive_t;
endpackage : ccpm_pkg
`default_nettype wire

// [rtl/ccpm_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   first stage feeds only the second
`default_nettype none
module ccpm_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_sys,   // system clock
   input  wire logic             rst,       // sync reset
   input  wire logic [WIDTH-1:0] async_in,  // raw pin levels
   output logic      [WIDTH-1:0] sync_out   // synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // two-stage resync
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : ccpm_sync
`default_nettype wire

// [rtl/ccpm_timer.sv]
// Purpose: free-running 16-bit time base with selectable tick
// Assumes: tick prescaler counts system clocks
// Notes:   wraps from maximum to zero
`default_nettype none
module ccpm_timer (
   input  wire logic        clk_sys,           // system clock
   input  wire logic        rst,               // sync reset
   input  wire logic        tick_rate_select,  // 1: half-microsecond counts
   output logic      [15:0] timer_value,       // current count
   output logic             timer_tick         // pulse on each count advance
);
   localparam logic [7:0] SLOW_LAST = 8'(ccpm_pkg::TICK_SLOW_CYC - 1);
   localparam logic [7:0] FAST_LAST = 8'(ccpm_pkg::TICK_FAST_CYC - 1);

   logic [7:0]  pre_q;
   logic [15:0] count_q;
   logic [7:0]  pre_last;

   assign pre_last   = tick_rate_select ? FAST_LAST : SLOW_LAST;
   assign timer_tick = (pre_q >= pre_last);

   // prescaler
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pre_q <= 8'h00;
      end else if (timer_tick) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // counter, wraps naturally
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_q <= ccpm_pkg::TIMER_RESET;
      end else if (timer_tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   assign timer_value = count_q;
endmodule : ccpm_timer
`default_nettype wire

// [rtl/ccpm_top.sv]
// Purpose: capture/compare unit with five-pin function multiplexer
// Assumes: control bits arrive as plain ports from the processor side
// Notes:   pins use separate in/out/oe signals; oe high means driven
//
// Summary of operation
// - all five pins input after reset
// - general mode wires pins to port bits
// - fixed pin to port and function map
// - configuration changes take effect immediately
// - priority: serial, then capture/compare, then port
// - select 01 forces pins one, three serial
// - pin direction follows selected function
// - strong drive holds output enable on
// - strong drive applies in every function
// - dedicated 16-bit free-running time base
// - tick of 1 or 0.5 microseconds
// - shadow loads timer only on request
// - capture enable turns pin into input
// - per channel rising or falling edge
// - edge copies timer, raises interrupt
// - compare enable turns pin into output
// - level bit sets driven match value
// - every match drives pin, raises interrupt
`default_nettype none
module ccpm_top (
   input  wire logic                     clk_sys,                 // system clock
   input  wire logic                     rst,                     // sync reset
   // configuration
   input  wire ccpm_pkg::ccpm_pin_select_t capcmp_pin_select_reg, // function enables
   input  wire ccpm_pkg::ccpm_control_t  capcmp_control_reg,      // rate, edges, levels
   input  wire logic [1:0]               digital_interface_select,// serial interface select
   input  wire logic [4:0]               strong_drive_bit,        // per-pin strong drive
   input  wire logic                     timer_latch_set,         // pulse: request shadow load
   output logic                          timer_latch_request,     // pending request flag
   output logic      [7:0]               timer_shadow_high,       // shadow high byte
   output logic      [7:0]               timer_shadow_low,        // shadow low byte
   input  wire logic [15:0]              compare_one_value,       // compare channel 1 value
   input  wire logic [15:0]              compare_two_value,       // compare channel 2 value
   output logic      [15:0]              capture_one_value,       // capture channel 1 register
   output logic      [15:0]              capture_two_value,       // capture channel 2 register
   output logic                          capture_one_irq,         // pulse on capture 1
   output logic                          capture_two_irq,         // pulse on capture 2
   output logic                          compare_one_irq,         // pulse on match 1
   output logic                          compare_two_irq,         // pulse on match 2
   // processor port side
   input  wire logic [4:0]               port_out,                // port bit values
   input  wire logic [4:0]               port_oe,                 // port bit directions
   output logic      [4:0]               port_in,                 // synced pin levels to port
   // serial interface side
   input  wire logic                     serial_data_out,         // data line drive value
   input  wire logic                     serial_data_oe,          // data line drive enable
   input  wire logic                     serial_clock_out,        // clock line drive value
   input  wire logic                     serial_clock_oe,         // clock line drive enable
   output logic                          serial_data_in,          // synced data line
   output logic                          serial_clock_in,         // synced clock line
   // pins
   input  wire logic [4:0]               pin_in,                  // pin levels
   output logic      [4:0]               pin_out,                 // pin drive values
   output logic      [4:0]               pin_oe,                  // pin output enables
   output logic      [1:0]               serial_mode_active       // pins one, three in serial use
);
   logic [15:0] timer_value;
   logic        timer_tick;
   logic [4:0]  pin_sync;
   logic        serial_sel;
   logic [1:0]  cap_active;
   logic [1:0]  cmp_active;
   logic [1:0]  cap_level;
   logic [1:0]  cap_prev_q;
   logic [1:0]  fill_q;
   logic [1:0]  cap_edge;
   logic [1:0]  cap_irq_q;
   logic [15:0] cap_value_q [2];
   logic [1:0]  cmp_level_q;
   logic [1:0]  cmp_irq_q;
   logic [1:0]  cmp_match;
   logic [1:0]  cmp_match_level;
   logic [15:0] cmp_value [2];
   logic [15:0] shadow_q;
   logic        latch_q;
   ccpm_pkg::ccpm_drive_t drive_d [5];

   // time base
   ccpm_timer u_timer (
      .clk_sys          (clk_sys),
      .rst              (rst),
      .tick_rate_select (capcmp_control_reg.tick_rate_select),
      .timer_value      (timer_value),
      .timer_tick       (timer_tick)
   );

   // pin input resync
   ccpm_sync #(.WIDTH(ccpm_pkg::PIN_COUNT)) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // function decode, combinational so writes act at once
   assign serial_sel    = (digital_interface_select == ccpm_pkg::DI_SEL_SERIAL2);
   assign cap_active[0] = capcmp_pin_select_reg.capture_one_enable & ~serial_sel;
   assign cap_active[1] = capcmp_pin_select_reg.capture_two_enable;
   assign cmp_active[0] = capcmp_pin_select_reg.compare_one_enable & ~serial_sel;
   assign cmp_active[1] = capcmp_pin_select_reg.compare_two_enable;
   assign serial_mode_active = {serial_sel, serial_sel};

   // capture pin levels
   assign cap_level[0] = pin_sync[ccpm_pkg::PIN_ONE];
   assign cap_level[1] = pin_sync[ccpm_pkg::PIN_TWO];
   assign cmp_value[0] = compare_one_value;
   assign cmp_value[1] = compare_two_value;
   assign cmp_match_level = {capcmp_control_reg.compare_two_match_level,
                             capcmp_control_reg.compare_one_match_level};

   // previous level for edge detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cap_prev_q <= 2'h0;
      end else begin
         cap_prev_q <= cap_level;
      end
   end

   // edge history fill; resync flops clear to 0 while an idle pin may sit high,
   // so edges are ignored until the history holds real pin levels
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fill_q <= 2'h0;
      end else if (fill_q != 2'h3) begin
         fill_q <= fill_q + 2'h1;
      end
   end

   // per-channel capture and compare
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      assign cap_edge[ch] = cap_active[ch] & (fill_q == 2'h3) &
                            (capcmp_control_reg.capture_edge_select[ch] ?
                             (cap_level[ch] & ~cap_prev_q[ch]) :
                             (~cap_level[ch] & cap_prev_q[ch]));
      // match once per timer count, on the tick that enters the value
      assign cmp_match[ch] = cmp_active[ch] & timer_tick &
                             (timer_value + 16'h0001 == cmp_value[ch]);

      // capture register and interrupt
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            cap_value_q[ch] <= ccpm_pkg::TIMER_RESET;
            cap_irq_q[ch]   <= 1'b0;
         end else begin
            cap_irq_q[ch] <= cap_edge[ch];
            if (cap_edge[ch]) begin
               cap_value_q[ch] <= timer_value;
            end
         end
      end

      // compare output level and interrupt
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            cmp_level_q[ch] <= 1'b0;
            cmp_irq_q[ch]   <= 1'b0;
         end else begin
            cmp_irq_q[ch] <= cmp_match[ch];
            if (cmp_match[ch]) begin
               cmp_level_q[ch] <= cmp_match_level[ch];
            end
         end
      end
   end

   assign capture_one_value = cap_value_q[0];
   assign capture_two_value = cap_value_q[1];
   assign capture_one_irq   = cap_irq_q[0];
   assign capture_two_irq   = cap_irq_q[1];
   assign compare_one_irq   = cmp_irq_q[0];
   assign compare_two_irq   = cmp_irq_q[1];

   // latch request flag; a new set wins over the self-clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         latch_q <= 1'b0;
      end else if (timer_latch_set) begin
         latch_q <= 1'b1;
      end else if (latch_q) begin
         latch_q <= 1'b0;
      end
   end

   // shadow loads only on request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shadow_q <= ccpm_pkg::TIMER_RESET;
      end else if (latch_q) begin
         shadow_q <= timer_value;
      end
   end

   assign timer_latch_request = latch_q;
   assign timer_shadow_high   = shadow_q[15:8];
   assign timer_shadow_low    = shadow_q[7:0];

   // per-pin function selection by priority
   always_comb begin
      for (int p = 0; p < ccpm_pkg::PIN_COUNT; p++) begin
         drive_d[p].out = port_out[p];
         drive_d[p].oe  = port_oe[p];
      end
      if (cap_active[0]) begin
         drive_d[ccpm_pkg::PIN_ONE] = '{out: 1'b0, oe: 1'b0};
      end
      if (cap_active[1]) begin
         drive_d[ccpm_pkg::PIN_TWO] = '{out: 1'b0, oe: 1'b0};
      end
      if (cmp_active[0]) begin
         drive_d[ccpm_pkg::PIN_THREE] = '{out: cmp_level_q[0], oe: 1'b1};
      end
      if (cmp_active[1]) begin
         drive_d[ccpm_pkg::PIN_FOUR] = '{out: cmp_level_q[1], oe: 1'b1};
      end
      if (serial_sel) begin
         drive_d[ccpm_pkg::PIN_ONE]   = '{out: serial_data_out, oe: serial_data_oe};
         drive_d[ccpm_pkg::PIN_THREE] = '{out: serial_clock_out, oe: serial_clock_oe};
      end
   end

   // pin drivers with strong-drive override
   for (genvar p = 0; p < ccpm_pkg::PIN_COUNT; p++) begin : g_pin
      assign pin_out[p] = drive_d[p].out;
      assign pin_oe[p]  = rst ? ccpm_pkg::PIN_OE_RESET[p] :
                          (drive_d[p].oe | strong_drive_bit[p]);
   end

   // synced levels back to port and serial block
   assign port_in         = pin_sync;
   assign serial_data_in  = pin_sync[ccpm_pkg::PIN_ONE];
   assign serial_clock_in = pin_sync[ccpm_pkg::PIN_THREE];
endmodule : ccpm_top
`default_nettype wire

// [testbench/ccpm_top_assertions.sv]
// Purpose: port-level checks for the capture/compare pin mux
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every ccpm_top by the bind at the foot
`default_nettype none
module ccpm_chk (
   input wire logic                       clk_sys,                  // clock
   input wire logic                       rst,                      // reset
   input wire ccpm_pkg::ccpm_pin_select_t capcmp_pin_select_reg,    // enables
   input wire ccpm_pkg::ccpm_control_t    capcmp_control_reg,       // levels
   input wire logic [1:0]                 digital_interface_select, // serial select
   input wire logic [4:0]                 strong_drive_bit,         // strong drive
   input wire logic                       timer_latch_set,          // latch pulse
   input wire logic                       timer_latch_request,      // pending latch
   input wire logic [7:0]                 timer_shadow_high,        // shadow high
   input wire logic [7:0]                 timer_shadow_low,         // shadow low
   input wire logic [15:0]                capture_one_value,        // capture reg
   input wire logic                       capture_one_irq,          // capture pulse
   input wire logic                       compare_one_irq,          // match pulse
   input wire logic [4:0]                 port_out,                 // port values
   input wire logic [4:0]                 port_oe,                  // port enables
   input wire logic                       serial_data_out,          // data drive
   input wire logic                       serial_data_oe,           // data enable
   input wire logic                       serial_clock_oe,          // clock enable
   input wire logic [4:0]                 pin_out,                  // pin values
   input wire logic [4:0]                 pin_oe,                   // pin enables
   input wire logic [1:0]                 serial_mode_active        // serial flags
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // serial code decode
   wire logic ser = digital_interface_select == 2'h1;
   // latch request raised, then left alone
   sequence s_lat;
      timer_latch_set ##1 timer_latch_request;
   endsequence
   sequence s_alone;
      s_lat ##0 !timer_latch_set;
   endsequence
   AST_SERIAL_FLAG: assert property (
      serial_mode_active == {2{ser}}) else $error("serial flag wrong");
   AST_SERIAL_WINS: assert property (
      ser |-> pin_oe[0] == (serial_data_oe | strong_drive_bit[0]) && pin_out[0] == serial_data_out
         && pin_oe[2] == (serial_clock_oe | strong_drive_bit[2])) else $error("serial pins not routed");
   AST_STRONG: assert property (
      (strong_drive_bit & ~pin_oe) == 5'h00) else $error("strong drive not holding enable");
   AST_PORT_FIVE: assert property (
      pin_oe[4] == (port_oe[4] | strong_drive_bit[4]) && pin_out[4] == port_out[4]) else $error("pin five not port");
   AST_CAP_INPUT: assert property (
      capcmp_pin_select_reg.capture_one_enable && !ser |-> pin_oe[0] == strong_drive_bit[0])
      else $error("capture pin driven");
   AST_CMP_LEVEL: assert property (
      compare_one_irq && capcmp_pin_select_reg.compare_one_enable && !ser
         |-> pin_oe[2] && pin_out[2] == capcmp_control_reg.compare_one_match_level) else $error("match level wrong");
   AST_CMP_GAP: assert property (
      compare_one_irq |=> !compare_one_irq [*8]) else $error("match pulse too close");
   AST_LATCH_RAISE: assert property (
      timer_latch_set |=> timer_latch_request) else $error("latch request missing");
   AST_LATCH_CLEAR: assert property (
      s_alone |=> !timer_latch_request) else $error("latch request stuck");
   AST_SHADOW_HOLD: assert property (
      !timer_latch_request |=> $stable({timer_shadow_high, timer_shadow_low})) else $error("shadow moved");
   AST_CAP_LOAD: assert property (
      !$past(rst) && $changed(capture_one_value) |-> capture_one_irq) else $error("capture without pulse");
endmodule : ccpm_chk
bind ccpm_top ccpm_chk u_ccpm_chk (.*);
`default_nettype wire

// [testbench/ccpm_pin_model.sv]
// Purpose: far-side model of the five pins
// Assumes: every pin has a pull-up when nobody drives it
// Notes:   device drive wins over the far side
`default_nettype none
module ccpm_pin_model (
   input  wire logic [4:0] pin_out,   // device values
   input  wire logic [4:0] pin_oe,    // device enables
   input  wire logic [4:0] ext_level, // far-side values
   input  wire logic [4:0] ext_drive, // far-side enables
   output logic      [4:0] pin_in     // wire levels
);
   timeunit 1ns;
   timeprecision 1ps;
   // resolve each wire from both parties
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level) | (~pin_oe & ~ext_drive);
endmodule : ccpm_pin_model
`default_nettype wire

// [testbench/ccpm_top_test.sv]
// Purpose: directed test of the capture/compare pin mux
// Assumes: inputs change 1 ns after the rising edge
// Notes:   pin levels seen by the design come from the pin model
`default_nettype none
module ccpm_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       clk_sys = 1'b0;
   logic                       rst = 1'b1;
   ccpm_pkg::ccpm_pin_select_t sel = '0;
   ccpm_pkg::ccpm_control_t    ctl = '0;
   logic [1:0]                 dis = 2'h0;
   logic [3:0]                 ser = 4'h0;  // data out, data oe, clock out, clock oe
   logic [4:0]                 sd = 5'h00, po = 5'h00, poe = 5'h1f, xl = 5'h00, xd = 5'h00;
   logic                       lat = 1'b0, lreq, ic1q, ic2q, oc1q, oc2q, sdi, sci;
   logic [7:0]                 shh, shl;
   logic [15:0]                c1v = 16'hffff, c2v = 16'hffff, cv1, cv2;
   logic [4:0]                 pin_p, pin_in, pin_out, pin_oe;
   logic [1:0]                 sma;
   int                         fail_count = 0, n_checks = 0, ic = 0, oc = 0;
   ccpm_top u_ccpm_top (
      .clk_sys(clk_sys), .rst(rst), .capcmp_pin_select_reg(sel), .capcmp_control_reg(ctl),
      .digital_interface_select(dis), .strong_drive_bit(sd), .timer_latch_set(lat),
      .timer_latch_request(lreq), .timer_shadow_high(shh), .timer_shadow_low(shl),
      .compare_one_value(c1v), .compare_two_value(c2v), .capture_one_value(cv1), .capture_two_value(cv2),
      .capture_one_irq(ic1q), .capture_two_irq(ic2q), .compare_one_irq(oc1q), .compare_two_irq(oc2q),
      .port_out(po), .port_oe(poe), .port_in(pin_p), .serial_data_out(ser[3]), .serial_data_oe(ser[2]),
      .serial_clock_out(ser[1]), .serial_clock_oe(ser[0]), .serial_data_in(sdi), .serial_clock_in(sci),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .serial_mode_active(sma));
   ccpm_pin_model u_ccpm_pin_model (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(xl), .ext_drive(xd), .pin_in(pin_in));
   // clock and event counters, pulses sampled mid-cycle where they are settled
   always #5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      ic += int'(ic1q === 1'b1) + int'(ic2q === 1'b1);
      oc += int'(oc1q === 1'b1) + int'(oc2q === 1'b1);
   end
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tk
   // one shadow latch request, returns the copied count
   task automatic rd(output logic [15:0] t);
      lat = 1'b1;
      tk(1);
      lat = 1'b0;
      tk(1);
      t = {shh, shl};
      chk("latch_clear", 16'(lreq), 16'h0000);
   endtask : rd
   task automatic print_verdict;
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      logic [15:0] t0, t1;
      int k;
      tk(5);
      chk("oe_reset", 16'(pin_oe), 16'h0000);
      rst = 1'b0;
      rd(t0);
      chk("timer_start", t0, 16'h0000);
      for (int r = 0; r < 2; r++) begin
         ctl.tick_rate_select = r[0];
         tk(120);
         rd(t0);
         tk(998);
         rd(t1);
         chk("timer_rate", t1 - t0, r ? 16'h0014 : 16'h000a);
         tk(200);
         chk("shadow_hold", {shh, shl}, t1);
      end
      po = 5'h15;
      tk(1);
      chk("gpio_out", 16'({pin_oe, pin_out}), 16'h03f5);
      poe = 5'h00;
      xd = 5'h1f;
      xl = 5'h0a;
      tk(3);
      chk("gpio_in", 16'({sci, sdi, pin_p, pin_oe}), 16'h0140);
      sd = 5'h1f;
      tk(1);
      chk("strong_gpio", 16'(pin_oe), 16'h001f);
      sel = 4'hf;
      dis = 2'h1;
      ser = 4'he;
      tk(1);
      chk("strong_alt", 16'(pin_oe), 16'h001f);
      sd = 5'h00;
      for (int d = 0; d < 4; d++) begin
         dis = d[1:0];
         tk(1);
         chk("serial_sel", 16'({sma, pin_oe, pin_out[2], pin_out[0]}), d == 1 ? 16'h01a7 : 16'h0030);
      end
      for (int e = 0; e < 2; e++) begin
         ctl.capture_edge_select = {2{~e[0]}};
         xl[1:0] = {2{e[0]}};
         tk(8);
         k = ic;
         xl[1:0] = {2{~e[0]}};
         tk(8);
         chk("cap_fire", 16'(ic - k), 16'h0002);
         rd(t0);
         chk("cap_value", 16'(t0 - cv1 < 16'h2 && cv1 == cv2), 16'h0001);
         xl[1:0] = {2{e[0]}};
         tk(8);
         chk("cap_other_edge", 16'(ic - k), 16'h0002);
      end
      ser = 4'h0;
      dis = 2'h1;
      sel.capture_two_enable = 1'b0;
      k = ic;
      xl[1:0] = 2'h3;
      tk(8);
      xl[1:0] = 2'h0;
      tk(8);
      chk("cap_refused", 16'(ic - k), 16'h0000);
      dis = 2'h0;
      for (int m = 0; m < 2; m++) begin
         ctl.compare_one_match_level = ~m[0];
         ctl.compare_two_match_level = m[0];
         rd(t0);
         k = oc;
         c1v = t0 + 16'h3;
         c2v = t0 + 16'h3;
         for (int i = 0; i < 400 && oc == k; i++) tk(1);
         tk(2);
         chk("cmp_fire", 16'(oc - k), 16'h0002);
         chk("cmp_pins", 16'({pin_oe[3:2], pin_out[3:2]}), m ? 16'h000e : 16'h000d);
      end
      print_verdict();
   end
   // hang guard, well past the expected run length
   initial begin
      #100us;
      fail_count++;
      print_verdict();
   end
endmodule : ccpm_top_test
`default_nettype wire
